// ### rtl/timer_counter_regs.vh
// Register offsets, field positions and reset values of the 16-bit timer/counter
`ifndef TIMER_COUNTER_REGS_VH
`define TIMER_COUNTER_REGS_VH
// ****************************************
// Register offsets
// ****************************************
`define ADDR_COUNT_LOW 4'h0
`define ADDR_COUNT_HIGH 4'h1
`define ADDR_TIMER_CONTROL 4'h2
`define ADDR_PERIPH_FLAG 4'h3
`define ADDR_PERIPH_ENABLE 4'h4
`define ADDR_OSC_CONTROL 4'h5
`define ADDR_PORT_C_DIR 4'h6
`define ADDR_COMPARE_LOW 4'h7
`define ADDR_COMPARE_HIGH 4'h8
`define ADDR_COMPARE_MODE 4'h9
// ****************************************
// Timer control fields
// ****************************************
`define TCON_RUN 0
`define TCON_SRC 1
`define TCON_SYNC_BYPASS 2
`define TCON_OSC_EN 3
`define TCON_PS_LO 4
`define TCON_PS_HI 5
`define TCON_CLK_ACTIVE 6
`define TCON_WIDE 7
// ****************************************
// Other fields and values
// ****************************************
`define FLAG_OVERFLOW 0
`define ENABLE_OVERFLOW 0
`define OSC_IDLE_ON_SLEEP 7
`define SCS_LOW_POWER 2'h1
`define CMP_MODE_TRIGGER 4'hB
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`define BYTE_ZERO 8'h00
`define PS_ZERO 3'h0
`define PS_DIV1 2'h0
`define PS_DIV2 2'h1
`define PS_DIV4 2'h2
`define PS_MASK1 3'h0
`define PS_MASK2 3'h1
`define PS_MASK4 3'h3
`define PS_MASK8 3'h7
`define PS_ONE 3'h1
`define COUNT_ONE 16'h0001
`define DIR_INPUTS 2'h3
`endif

// ### rtl/sixteen_bit_timer_counter.v
// 16-bit up-counting timer/counter with low-power oscillator control and compare reset
`timescale 1ns/1ps
`include "timer_counter_regs.vh"

module sixteen_bit_timer_counter
(
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Pins: bit 0 external_count_input, bit 1 crystal_input_pin
   input wire [1:0] pin_in,
   output wire [1:0] pin_out,
   output wire [1:0] pin_oe,
   // Oscillator and system clock
   output wire osc_enable,
   input wire osc_fail,
   input wire sleep_cmd,
   input wire wake_event,
   output wire sys_clk_from_osc,
   output reg sec_idle,
   // Interrupt request
   output wire irq_request
);

   // ****************************************
   // Register storage
   // ****************************************
   reg [15:0] count;
   reg [7:0] high_buffer;
   reg [2:0] prescale_count;
   reg wide_access_enable;
   reg [1:0] input_prescale_select;
   reg low_power_osc_enable;
   reg external_sync_bypass;
   reg count_source_select;
   reg timer_run_enable;
   reg overflow_flag;
   reg overflow_irq_enable;
   reg idle_on_sleep_enable;
   reg [1:0] system_clock_select;
   reg [1:0] port_c_direction;
   reg [1:0] port_latch;
   reg [15:0] compare_value_pair;
   reg [3:0] compare_mode_field;
   reg osc_failed;
   // Pin synchronisers; stage one feeds only stage two
   reg [1:0] pin_meta;
   reg [1:0] pin_sync;
   reg [1:0] pin_prev;

   wire [7:0] timer_control_reg;
   wire secondary_clock_active_flag;
   wire async_mode;
   wire src_edge;
   wire count_event;
   wire ps_tick;
   wire do_count;
   wire trigger_reset;
   wire write_low;
   wire write_high;
   wire [15:0] next_count_inc;

   // ****************************************
   // Helper functions
   // ****************************************
   function [2:0] ps_mask;
      input [1:0] sel;
      begin
         case (sel)
            `PS_DIV1: ps_mask = `PS_MASK1;
            `PS_DIV2: ps_mask = `PS_MASK2;
            `PS_DIV4: ps_mask = `PS_MASK4;
            default: ps_mask = `PS_MASK8;
         endcase
      end
   endfunction
   function hit;
      input [3:0] addr;
      input [3:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // ****************************************
   // Pin synchronisation
   // ****************************************
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
         pin_prev <= 2'h0;
      end
      else
      begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // ****************************************
   // Count clock selection
   // ****************************************
   // One clock only, so the unsynchronized mode still samples through the
   // synchroniser; it differs only in refusing trigger resets.
   assign async_mode = count_source_select & external_sync_bypass;
   assign src_edge = low_power_osc_enable ? (pin_sync[1] & ~pin_prev[1]) :
                     (pin_sync[0] & ~pin_prev[0]);
   assign count_event = count_source_select ? src_edge : 1'b1;
   assign ps_tick = count_event &
                    (prescale_count == ps_mask(input_prescale_select));
   assign do_count = timer_run_enable & ps_tick;
   assign next_count_inc = count + `COUNT_ONE;
   // Compare match resets the count; refused in async mode
   assign trigger_reset = (compare_mode_field == `CMP_MODE_TRIGGER) &
                          (count == compare_value_pair) &
                          timer_run_enable & ~async_mode;
   assign write_low = reg_wr & hit(reg_addr, `ADDR_COUNT_LOW);
   assign write_high = reg_wr & hit(reg_addr, `ADDR_COUNT_HIGH);

   // ****************************************
   // Count, buffer and prescaler
   // ****************************************
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         count <= `COUNT_ZERO;
         high_buffer <= `BYTE_ZERO;
         prescale_count <= `PS_ZERO;
      end
      else
      begin
         if (write_low)
         begin
            prescale_count <= `PS_ZERO;
            if (wide_access_enable)
               count <= {high_buffer, reg_wdata};
            else
               count <= {count[15:8], reg_wdata};
         end
         else if (write_high)
         begin
            if (wide_access_enable)
               high_buffer <= reg_wdata;
            else
               count <= {reg_wdata, count[7:0]};
         end
         else if (trigger_reset)
            count <= `COUNT_ZERO;
         else if (do_count)
            count <= next_count_inc;
         if (!write_low && timer_run_enable && count_event)
         begin
            if (ps_tick)
               prescale_count <= `PS_ZERO;
            else
               prescale_count <= prescale_count + `PS_ONE;
         end
         if (reg_rd && hit(reg_addr, `ADDR_COUNT_LOW) && wide_access_enable)
            high_buffer <= count[15:8];
      end
   end

   // ****************************************
   // Overflow flag
   // ****************************************
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         overflow_flag <= 1'b0;
      else if (do_count && !write_low && !write_high && !trigger_reset &&
               count == `COUNT_MAX)
         overflow_flag <= 1'b1;
      else if (reg_wr && hit(reg_addr, `ADDR_PERIPH_FLAG))
         overflow_flag <= reg_wdata[`FLAG_OVERFLOW];
   end

   assign irq_request = overflow_flag & overflow_irq_enable;

   // ****************************************
   // Control registers
   // ****************************************
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         wide_access_enable <= 1'b0;
         input_prescale_select <= `PS_DIV1;
         low_power_osc_enable <= 1'b0;
         external_sync_bypass <= 1'b0;
         count_source_select <= 1'b0;
         timer_run_enable <= 1'b0;
         overflow_irq_enable <= 1'b0;
         idle_on_sleep_enable <= 1'b0;
         system_clock_select <= 2'h0;
         port_c_direction <= `DIR_INPUTS;
         port_latch <= 2'h0;
         compare_value_pair <= `COUNT_ZERO;
         compare_mode_field <= 4'h0;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `ADDR_TIMER_CONTROL:
            begin
               wide_access_enable <= reg_wdata[`TCON_WIDE];
               input_prescale_select <= reg_wdata[`TCON_PS_HI:`TCON_PS_LO];
               low_power_osc_enable <= reg_wdata[`TCON_OSC_EN];
               external_sync_bypass <= reg_wdata[`TCON_SYNC_BYPASS];
               count_source_select <= reg_wdata[`TCON_SRC];
               timer_run_enable <= reg_wdata[`TCON_RUN];
            end
            `ADDR_PERIPH_ENABLE: overflow_irq_enable <= reg_wdata[`ENABLE_OVERFLOW];
            `ADDR_OSC_CONTROL:
            begin
               idle_on_sleep_enable <= reg_wdata[`OSC_IDLE_ON_SLEEP];
               system_clock_select <= reg_wdata[1:0];
            end
            `ADDR_PORT_C_DIR:
            begin
               port_c_direction <= reg_wdata[1:0];
               port_latch <= reg_wdata[5:4];
            end
            `ADDR_COMPARE_LOW: compare_value_pair[7:0] <= reg_wdata;
            `ADDR_COMPARE_HIGH: compare_value_pair[15:8] <= reg_wdata;
            `ADDR_COMPARE_MODE: compare_mode_field <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // System clock status and secondary idle
   // ****************************************
   // Fallback latches until software reselects the clock
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         osc_failed <= 1'b0;
      else if (osc_fail)
         osc_failed <= 1'b1;
      else if (reg_wr && hit(reg_addr, `ADDR_OSC_CONTROL))
         osc_failed <= 1'b0;
   end

   assign osc_enable = low_power_osc_enable;
   assign sys_clk_from_osc = (system_clock_select == `SCS_LOW_POWER) &
                             low_power_osc_enable & ~osc_failed;
   assign secondary_clock_active_flag = sys_clk_from_osc;

   always @(posedge clk_sys)
   begin
      if (!rst_n)
         sec_idle <= 1'b0;
      else if (sleep_cmd && sys_clk_from_osc && !idle_on_sleep_enable)
         sec_idle <= 1'b1;
      else if (wake_event || !sys_clk_from_osc)
         sec_idle <= 1'b0;
   end

   // ****************************************
   // Pins
   // ****************************************
   // Port drivers are cut while the timer runs so the count input is never fought
   assign pin_oe = timer_run_enable ? 2'h0 : ~port_c_direction;
   assign pin_out = port_latch;

   // ****************************************
   // Read data
   // ****************************************
   assign timer_control_reg = {wide_access_enable, secondary_clock_active_flag,
                               input_prescale_select, low_power_osc_enable,
                               external_sync_bypass, count_source_select,
                               timer_run_enable};

   always @(posedge clk_sys)
   begin
      if (!rst_n || !reg_rd)
         reg_rdata <= `BYTE_ZERO;
      else
      begin
         case (reg_addr)
            `ADDR_COUNT_LOW: reg_rdata <= count[7:0];
            `ADDR_COUNT_HIGH: reg_rdata <= wide_access_enable ? high_buffer :
                                           count[15:8];
            `ADDR_TIMER_CONTROL: reg_rdata <= timer_control_reg;
            `ADDR_PERIPH_FLAG: reg_rdata <= {7'h00, overflow_flag};
            `ADDR_PERIPH_ENABLE: reg_rdata <= {7'h00, overflow_irq_enable};
            `ADDR_OSC_CONTROL: reg_rdata <= {idle_on_sleep_enable, 5'h00,
                                             system_clock_select};
            `ADDR_PORT_C_DIR: reg_rdata <= {2'h0, port_latch,
                                            timer_run_enable ? 2'h0 : pin_sync,
                                            port_c_direction};
            `ADDR_COMPARE_LOW: reg_rdata <= compare_value_pair[7:0];
            `ADDR_COMPARE_HIGH: reg_rdata <= compare_value_pair[15:8];
            `ADDR_COMPARE_MODE: reg_rdata <= {4'h0, compare_mode_field};
            default: reg_rdata <= `BYTE_ZERO;
         endcase
      end
   end

endmodule // sixteen_bit_timer_counter

// ### sim/sixteen_bit_timer_counter_chk.sv
// Port assertions of the 16-bit timer/counter
`timescale 1ns/1ps
`include "timer_counter_regs.vh"
module sixteen_bit_timer_counter_chk
(
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Pins and status
   input wire [1:0] pin_oe,
   input wire osc_enable,
   input wire osc_fail,
   input wire sleep_cmd,
   input wire wake_event,
   input wire sys_clk_from_osc,
   input wire sec_idle,
   input wire irq_request
);
   reg run_bit;
   reg idle_bit;
   wire ctl_wr = reg_wr && reg_addr == `ADDR_TIMER_CONTROL;
   wire osc_wr = reg_wr && reg_addr == `ADDR_OSC_CONTROL;
   // Shadow of the written bits, so no hidden state is needed
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         run_bit <= 1'b0;
         idle_bit <= 1'b0;
      end
      else
      begin
         if (ctl_wr)
            run_bit <= reg_wdata[`TCON_RUN];
         if (osc_wr)
            idle_bit <= reg_wdata[`OSC_IDLE_ON_SLEEP];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ****
   // Assertions
   // ****
   run_inputs_a: assert property (run_bit |-> pin_oe == 2'b00)
      else $error("pin driven while timer runs");
   pin_read_a: assert property (reg_rd && reg_addr == `ADDR_PORT_C_DIR && run_bit
      |=> reg_rdata[3:2] == 2'b00) else $error("pin level read while running");
   osc_follow_a: assert property (ctl_wr
      |=> osc_enable == $past(reg_wdata[`TCON_OSC_EN])) else $error("osc enable wrong");
   clk_status_a: assert property (reg_rd && reg_addr == `ADDR_TIMER_CONTROL
      |=> reg_rdata[`TCON_CLK_ACTIVE] == $past(sys_clk_from_osc))
      else $error("clock status bit wrong");
   fail_fallback_a: assert property (osc_fail && !osc_wr |=> !sys_clk_from_osc)
      else $error("osc clock kept after fail");
   clk_select_a: assert property (osc_wr && reg_wdata[1:0] == `SCS_LOW_POWER
      && osc_enable && !osc_fail |=> sys_clk_from_osc) else $error("osc clock not taken");
   idle_enter_a: assert property (sleep_cmd && sys_clk_from_osc && !idle_bit
      && !wake_event && !osc_fail |=> sec_idle) else $error("secondary idle not entered");
   idle_leave_a: assert property (wake_event && !sleep_cmd |=> !sec_idle)
      else $error("secondary idle not left");
   irq_mask_a: assert property (reg_wr && reg_addr == `ADDR_PERIPH_ENABLE
      && !reg_wdata[`ENABLE_OVERFLOW] |=> !irq_request) else $error("masked irq raised");
endmodule // sixteen_bit_timer_counter_chk

bind sixteen_bit_timer_counter sixteen_bit_timer_counter_chk i_sixteen_bit_timer_counter_chk
(
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_oe(pin_oe),
   .osc_enable(osc_enable), .osc_fail(osc_fail), .sleep_cmd(sleep_cmd),
   .wake_event(wake_event), .sys_clk_from_osc(sys_clk_from_osc), .sec_idle(sec_idle),
   .irq_request(irq_request)
);

// ### sim/ext_source.sv
// Model of the external count pin and the crystal pin
`timescale 1ns/1ps
module ext_source
(
   // Pin levels
   output reg [1:0] pin_in
);
   initial pin_in = 2'b00;
   // Edges only inside a burst; pins rest low between bursts
   task burst(input integer sel, input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1)
         begin
            #23 pin_in[sel] = 1'b1;
            #23 pin_in[sel] = 1'b0;
         end
      end
   endtask
endmodule // ext_source

// ### sim/tb_sixteen_bit_timer_counter.sv
// Self-checking testbench of the 16-bit timer/counter
`timescale 1ns/1ps
`include "timer_counter_regs.vh"
module tb_sixteen_bit_timer_counter;
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg osc_fail = 1'b0;
   reg sleep_cmd = 1'b0;
   reg wake_event = 1'b0;
   wire [7:0] reg_rdata;
   wire [1:0] pin_in;
   wire [1:0] pin_oe;
   wire [1:0] pin_out;
   wire osc_enable;
   wire sys_clk_from_osc;
   wire sec_idle;
   wire irq_request;
   integer mismatches = 0;
   integer n_compared = 0;
   integer i;
   // Rows: prescale field, count after 24 timer cycles
   reg [9:0] rows [0:3];
   always #2.5 clk_sys = ~clk_sys;
   sixteen_bit_timer_counter i_sixteen_bit_timer_counter
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .osc_enable(osc_enable), .osc_fail(osc_fail),
      .sleep_cmd(sleep_cmd), .wake_event(wake_event), .sys_clk_from_osc(sys_clk_from_osc),
      .sec_idle(sec_idle), .irq_request(irq_request)
   );
   ext_source i_ext_source (.pin_in(pin_in));
   // ****
   // Tasks
   // ****
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   task rc(input [3:0] a, input [7:0] e);
      begin
         @(posedge clk_sys);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1;
         n_compared = n_compared + 1;
         if (reg_rdata !== e)
         begin
            mismatches = mismatches + 1;
            $display("MISMATCH reg %h exp %h got %h", a, e, reg_rdata);
         end
      end
   endtask
   task cf(input string n, input e, input g);
      begin
         n_compared = n_compared + 1;
         if (g !== e)
         begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0s exp %b got %b", n, e, g);
         end
      end
   endtask
   task stop_test;
      begin
         $display("compared %0d mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // Whole run is a few hundred cycles
   initial
   begin
      #100000;
      mismatches = mismatches + 1;
      stop_test;
   end
   // ****
   // Main sequence
   // ****
   initial
   begin
      rows[0] = {`PS_DIV1, 8'h18};
      rows[1] = {`PS_DIV2, 8'h0C};
      rows[2] = {`PS_DIV4, 8'h06};
      rows[3] = {2'h3, 8'h03};
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      rc(`ADDR_TIMER_CONTROL, 8'h00);
      rc(`ADDR_PORT_C_DIR, 8'h03);
      rc(4'hF, 8'h00);
      wr(`ADDR_PORT_C_DIR, 8'h30);
      cf("oe", 1'b1, &pin_oe);
      cf("out", 1'b1, &pin_out);
      // Run spans exactly 24 edges: two writes 24 cycles apart
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(`ADDR_COUNT_HIGH, `BYTE_ZERO);
         wr(`ADDR_COUNT_LOW, `BYTE_ZERO);
         wr(`ADDR_TIMER_CONTROL, {2'h0, rows[i][9:8], 4'h1});
         cf("oe", 1'b0, |pin_oe);
         repeat (22) @(posedge clk_sys);
         wr(`ADDR_TIMER_CONTROL, {2'h0, rows[i][9:8], 4'h0});
         rc(`ADDR_COUNT_LOW, rows[i][7:0]);
         rc(`ADDR_COUNT_HIGH, `BYTE_ZERO);
      end
      wr(`ADDR_COUNT_HIGH, 8'h12);
      wr(`ADDR_COUNT_LOW, 8'h34);
      wr(`ADDR_TIMER_CONTROL, 8'h80);
      wr(`ADDR_COUNT_HIGH, 8'h55);
      rc(`ADDR_COUNT_HIGH, 8'h55);
      rc(`ADDR_COUNT_LOW, 8'h34);
      rc(`ADDR_COUNT_HIGH, 8'h12);
      wr(`ADDR_COUNT_HIGH, 8'hA5);
      wr(`ADDR_COUNT_LOW, 8'h5A);
      wr(`ADDR_TIMER_CONTROL, 8'h00);
      rc(`ADDR_COUNT_HIGH, 8'hA5);
      rc(`ADDR_COUNT_LOW, 8'h5A);
      wr(`ADDR_PERIPH_ENABLE, 8'h01);
      wr(`ADDR_COUNT_HIGH, 8'hFF);
      wr(`ADDR_COUNT_LOW, 8'hFE);
      cf("irq", 1'b0, irq_request);
      wr(`ADDR_TIMER_CONTROL, 8'h01);
      wr(`ADDR_TIMER_CONTROL, 8'h00);
      rc(`ADDR_COUNT_LOW, 8'h00);
      rc(`ADDR_COUNT_HIGH, 8'h00);
      rc(`ADDR_PERIPH_FLAG, 8'h01);
      cf("irq", 1'b1, irq_request);
      wr(`ADDR_PERIPH_ENABLE, 8'h00);
      cf("irq", 1'b0, irq_request);
      wr(`ADDR_PERIPH_FLAG, 8'h00);
      rc(`ADDR_PERIPH_FLAG, 8'h00);
      wr(`ADDR_COMPARE_LOW, 8'h05);
      wr(`ADDR_COMPARE_HIGH, 8'h00);
      wr(`ADDR_COMPARE_MODE, {4'h0, `CMP_MODE_TRIGGER});
      wr(`ADDR_COUNT_LOW, 8'h00);
      wr(`ADDR_TIMER_CONTROL, 8'h01);
      repeat (18) @(posedge clk_sys);
      wr(`ADDR_TIMER_CONTROL, 8'h00);
      rc(`ADDR_COUNT_LOW, 8'h02);
      rc(`ADDR_PERIPH_FLAG, 8'h00);
      // Match at zero pins the count; a coincident write still lands
      wr(`ADDR_COMPARE_LOW, 8'h00);
      wr(`ADDR_COUNT_LOW, 8'h00);
      wr(`ADDR_TIMER_CONTROL, 8'h01);
      wr(`ADDR_COUNT_LOW, 8'h77);
      wr(`ADDR_TIMER_CONTROL, 8'h00);
      rc(`ADDR_COUNT_LOW, 8'h79);
      // Trigger at FFFFh clears the count without a wrap
      wr(`ADDR_COMPARE_LOW, 8'hFF);
      wr(`ADDR_COMPARE_HIGH, 8'hFF);
      wr(`ADDR_COUNT_HIGH, 8'hFF);
      wr(`ADDR_COUNT_LOW, 8'hFE);
      wr(`ADDR_TIMER_CONTROL, 8'h01);
      wr(`ADDR_TIMER_CONTROL, 8'h00);
      rc(`ADDR_COUNT_HIGH, 8'h00);
      rc(`ADDR_PERIPH_FLAG, 8'h00);
      // Clock-keeping use: async counting ignores the trigger and wraps
      wr(`ADDR_PERIPH_ENABLE, 8'h01);
      wr(`ADDR_COUNT_HIGH, 8'hFF);
      wr(`ADDR_COUNT_LOW, 8'hFE);
      wr(`ADDR_TIMER_CONTROL, 8'h0F);
      i_ext_source.burst(1, 2);
      repeat (8) @(posedge clk_sys);
      cf("irq", 1'b1, irq_request);
      wr(`ADDR_COUNT_HIGH, 8'h80);
      wr(`ADDR_PERIPH_FLAG, 8'h00);
      cf("irq", 1'b0, irq_request);
      rc(`ADDR_COUNT_HIGH, 8'h80);
      rc(`ADDR_COUNT_LOW, 8'h00);
      wr(`ADDR_COMPARE_MODE, 8'h00);
      wr(`ADDR_COUNT_LOW, 8'h00);
      wr(`ADDR_TIMER_CONTROL, 8'h03);
      i_ext_source.burst(0, 5);
      repeat (8) @(posedge clk_sys);
      rc(`ADDR_PORT_C_DIR, 8'h30);
      wr(`ADDR_TIMER_CONTROL, 8'h0B);
      repeat (10) @(posedge clk_sys);
      i_ext_source.burst(0, 3);
      i_ext_source.burst(1, 4);
      repeat (8) @(posedge clk_sys);
      wr(`ADDR_TIMER_CONTROL, 8'h08);
      rc(`ADDR_COUNT_LOW, 8'h09);
      cf("osc", 1'b1, osc_enable);
      wr(`ADDR_OSC_CONTROL, {6'h00, `SCS_LOW_POWER});
      cf("sys", 1'b1, sys_clk_from_osc);
      rc(`ADDR_TIMER_CONTROL, 8'h48);
      @(posedge clk_sys);
      sleep_cmd <= 1'b1;
      @(posedge clk_sys);
      sleep_cmd <= 1'b0;
      #1 cf("idle", 1'b1, sec_idle);
      @(posedge clk_sys);
      wake_event <= 1'b1;
      @(posedge clk_sys);
      wake_event <= 1'b0;
      #1 cf("idle", 1'b0, sec_idle);
      @(posedge clk_sys);
      osc_fail <= 1'b1;
      @(posedge clk_sys);
      osc_fail <= 1'b0;
      #1 cf("sys", 1'b0, sys_clk_from_osc);
      rc(`ADDR_TIMER_CONTROL, 8'h08);
      stop_test;
   end
endmodule // tb_sixteen_bit_timer_counter
